/* File: hdl/sirt_pkg.sv */
`default_nettype none
package sirt_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] BASE_OFF      = 12'h064;
  localparam logic [11:0] STAT_OFF      = 12'h068;
  localparam int          BASE_LSB      = 11;
  localparam int          FAULT_BIT     = 31;
  localparam int          EPOCH_LSB     = 16;
  localparam int          EPOCH_W       = 8;
  localparam int          CNT_LSB       = 2;
  localparam int          CNT_W         = 9;
  localparam logic [20:0] BASE_RST      = 21'h000000;
  localparam logic [7:0]  EPOCH_RST     = 8'h00;
  localparam logic [8:0]  CNT_RST       = 9'h000;
  localparam logic [8:0]  CNT_MAX       = 9'h1ff;
  localparam logic [31:0] STAT_RSVD     = 32'h7f00f803;
  // ---------------------------------------------------------------
  // Receive buffering
  // ---------------------------------------------------------------
  localparam int          FIFO_DEPTH    = 16;
  localparam int          QUAD_W        = 32;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } sirt_mem_wr_t;
endpackage
`default_nettype wire

/* File: hdl/sirt_top.sv */
// Overview of operation
// - Pointer is the 2K-byte aligned host base for identity packets.
// - Pointer bits 31 to 11 are written and read back by software.
// - Pointer bits 10 to 0 ignore writes and always read zero.
// - Status bit 31 is set when the latest reception saw any error.
// - While that fault bit is set the buffer contents are undefined.
// - A clean reception clears the fault bit; only hardware changes it.
// - Data errors and failed host writes both raise the fault bit.
// - Status bits 23 to 16 count bus resets, one step per reset.
// - That epoch counter wraps from 255 to zero.
// - Status bits 10 to 2 give the quadlets written this reception.
// - That count stops at 511; quadlets past the 511th are dropped unwritten.
// - The count returns to zero when a new reception starts.
// - Status bits 30 to 24, 15 to 11 and 1 to 0 read as zero.
// - Status sits at 0x68, is read-only and resets with a zero count.
//
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------
// Quadlet FIFO
// -----------------------------------------------------------------
module sirt_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      // Registered so the link sees a flop, costs no throughput
      in_ready <= (cnt_d != FULL);
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule // sirt_fifo

// -----------------------------------------------------------------
// Identity receive tracker
// -----------------------------------------------------------------
module sirt_top #(
  parameter int FIFO_D = sirt_pkg::FIFO_DEPTH
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [sirt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    bus_reset_seen,
  input  wire logic                    rx_start,
  input  wire logic                    rx_end,
  input  wire logic                    rx_error,
  input  wire logic                    rx_valid,
  output logic                         rx_ready,
  input  wire logic [31:0]             rx_data,
  output var  logic                    mem_req,
  output var  sirt_pkg::sirt_mem_wr_t  mem_wr,
  input  wire logic                    mem_ack,
  input  wire logic                    mem_err
);
  import sirt_pkg::*;

  typedef enum logic {WR_IDLE, WR_BUSY} sirt_wr_state_t;

  logic [20:0]        base_q;
  logic               fault_q;
  logic [EPOCH_W-1:0] epoch_q;
  logic [CNT_W-1:0]   cnt_q;
  logic               err_acc_q;
  logic               end_pend_q;
  sirt_wr_state_t     wr_q;
  logic               fq_valid;
  logic               fq_pop;
  logic [31:0]        fq_data;
  logic               finish;
  logic               acc_ok;
  logic               setup;
  logic [31:0]        base_word;
  logic [31:0]        stat_word;

  // ---------------------------------------------------------------
  // Quadlet buffering
  // ---------------------------------------------------------------
  sirt_fifo #(
    .W (QUAD_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (fq_valid),
    .out_ready (fq_pop),
    .out_data  (fq_data)
  );

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign setup     = psel & penable & ~pready;
  assign base_word = {base_q, 11'h000};
  assign stat_word = {fault_q, 7'h00, epoch_q, 5'h00,
                      cnt_q, 2'h0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (setup) begin
        if (paddr == BASE_OFF) begin
          prdata <= base_word;
        end else if (paddr == STAT_OFF) begin
          prdata <= pwrite ? 32'h00000000 : stat_word;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Write lands at the completing edge, when the master sees pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= BASE_RST;
    end else if (psel & penable & pready & pwrite & (paddr == BASE_OFF)) begin
      base_q <= pwdata[31:BASE_LSB];
    end
  end

  // ---------------------------------------------------------------
  // Bus reset epoch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epoch_q <= EPOCH_RST;
    end else if (bus_reset_seen) begin
      epoch_q <= epoch_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Host memory writer
  // ---------------------------------------------------------------
  assign fq_pop = (wr_q == WR_IDLE) & fq_valid & ~rx_start;
  assign acc_ok = (wr_q == WR_BUSY) & mem_ack;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q    <= WR_IDLE;
      mem_req <= 1'b0;
      mem_wr  <= '0;
    end else begin
      case (wr_q)
        WR_IDLE: begin
          // Quadlets past the 511th are dropped rather than wrapped onto the header
          if (fq_pop && cnt_q != CNT_MAX) begin
            mem_req     <= 1'b1;
            mem_wr.addr <= base_word
                           | {21'h000000, cnt_q, 2'h0};
            mem_wr.data <= fq_data;
            wr_q        <= WR_BUSY;
          end
        end
        WR_BUSY: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            wr_q    <= WR_IDLE;
          end
        end
        default: begin
          mem_req <= 1'b0;
          wr_q    <= WR_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Quadlet count and fault tracking
  // ---------------------------------------------------------------
  assign finish = end_pend_q & ~fq_valid & (wr_q == WR_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CNT_RST;
    end else if (rx_start) begin
      cnt_q <= CNT_RST;
    end else if (acc_ok) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_acc_q  <= 1'b0;
      end_pend_q <= 1'b0;
    end else begin
      if ((rx_end & rx_error) | (acc_ok & mem_err)
          | (fq_pop & (cnt_q == CNT_MAX))) begin
        err_acc_q <= 1'b1;
      end else if (rx_start) begin
        err_acc_q <= 1'b0;
      end
      if (rx_end) begin
        end_pend_q <= 1'b1;
      end else if (rx_start | finish) begin
        end_pend_q <= 1'b0;
      end
    end
  end

  // Buffer contents are not to be trusted while this reads one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (finish) begin
      fault_q <= err_acc_q;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel & ~penable;
  endsequence
  sequence s_access;
    psel & penable & ~pready;
  endsequence
  sequence s_ptr_wr;
    psel & penable & pready & pwrite & (paddr == BASE_OFF);
  endsequence
  sequence s_ptr_rd;
    setup & ~pwrite & (paddr == BASE_OFF);
  endsequence
  sequence s_req_wait;
    mem_req & ~mem_ack;
  endsequence

  a_apb_answer: assert property (s_setup ##1 s_access |=> pready)
    else $error("apb access not answered in one cycle");

  a_ptr_low_zero: assert property (
    pready & (paddr == BASE_OFF) & ~pwrite |-> prdata[10:0] == 11'h000)
    else $error("pointer low bits not zero");

  // Write takes effect only at the completing edge of the access
  a_ptr_write: assert property (
    s_ptr_wr |=> base_q == $past(pwdata[31:BASE_LSB]))
    else $error("pointer write did not land");

  a_ptr_read: assert property (
    s_ptr_rd |=> prdata == {$past(base_q), 11'h000})
    else $error("pointer readback differs");

  a_stat_rsvd: assert property (
    pready & (paddr == STAT_OFF) |-> (prdata & STAT_RSVD) == 32'h0)
    else $error("status reserved bits not zero");

  a_epoch_step: assert property (
    bus_reset_seen |=> epoch_q == 8'($past(epoch_q) + 8'h01))
    else $error("epoch did not step");

  a_count_clear: assert property (rx_start |=> cnt_q == 9'h000)
    else $error("count not cleared at start");

  a_count_step: assert property (
    acc_ok & ~rx_start |=> cnt_q == 9'($past(cnt_q) + 9'h001))
    else $error("count did not step on write");

  a_wr_addr: assert property (
    $rose(mem_req) |-> mem_wr.addr
      == ({$past(base_q), 11'h000} | {21'h0, $past(cnt_q), 2'h0}))
    else $error("write address wrong");

  a_fault_update: assert property (
    finish |=> fault_q == $past(err_acc_q))
    else $error("fault flag not updated at finish");

  a_fault_hold: assert property (~finish |=> $stable(fault_q))
    else $error("fault flag changed outside finish");

  a_ready_pulse: assert property (pready |=> ~pready)
    else $error("pready held longer than one cycle");

  a_unmapped_err: assert property (
    setup & (paddr != BASE_OFF) & (paddr != STAT_OFF) |=> pslverr)
    else $error("unmapped access without error");

  a_stat_read: assert property (
    setup & ~pwrite & (paddr == STAT_OFF)
    |=> prdata == {$past(fault_q), 7'h00, $past(epoch_q), 5'h00,
                   $past(cnt_q), 2'h0})
    else $error("status read differs from its fields");

  a_epoch_hold: assert property (
    ~bus_reset_seen |=> $stable(epoch_q))
    else $error("epoch changed without bus reset");

  a_count_hold: assert property (
    ~rx_start & ~acc_ok |=> $stable(cnt_q))
    else $error("count changed without a write");

  // A held request may not change under the memory's feet
  a_req_hold: assert property (
    s_req_wait |=> mem_req & $stable(mem_wr))
    else $error("write request dropped or changed before ack");

  // Overflow keeps the header safe: nothing is written past 511
  a_drop_full: assert property (
    fq_pop & (cnt_q == CNT_MAX) |=> ~mem_req)
    else $error("quadlet past the count limit was written");
endmodule // sirt_top
`default_nettype wire

/* File: sim/sirt_host_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Host memory model
// ---------------------------------------------------------------
module sirt_host_mem (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   mem_req,
  input  wire sirt_pkg::sirt_mem_wr_t mem_wr,
  input  wire logic [7:0]             delay,
  input  wire logic                   fail,
  output logic                        mem_ack,
  output logic                        mem_err,
  output logic [31:0]                 last_addr,
  output logic [31:0]                 last_data,
  output logic [15:0]                 writes
);
  import sirt_pkg::*;
  logic [7:0] wait_q;
  // Error line toggles between acks: it means something only with ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      wait_q    <= 8'h00;
      writes    <= 16'h0000;
      last_addr <= 32'h00000000;
      last_data <= 32'h00000000;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_err <= ~mem_err;
    end else if (mem_req && wait_q >= delay) begin
      mem_ack   <= 1'b1;
      mem_err   <= fail;
      wait_q    <= 8'h00;
      last_addr <= mem_wr.addr;
      last_data <= mem_wr.data;
      writes    <= writes + 16'h0001;
    end else begin
      mem_err <= ~mem_err;
      if (mem_req) wait_q <= wait_q + 8'h01;
    end
  end
endmodule // sirt_host_mem
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sirt_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, pready;
  logic                pslverr, bus_reset_seen, rx_start, rx_end;
  logic                rx_error, rx_valid, rx_ready, mem_req, mem_ack;
  logic                mem_err, fail, err, saw_full;
  logic [ADDR_W-1:0]   paddr;
  logic [31:0]         pwdata, prdata, rx_data, rd, last_addr, last_data;
  logic [7:0]          delay;
  logic [15:0]         writes;
  sirt_mem_wr_t        mem_wr;
  int                  mismatches, compares, cycles;

  sirt_top #(.FIFO_D(16)) i_sirt_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_reset_seen(bus_reset_seen),
    .rx_start(rx_start), .rx_end(rx_end), .rx_error(rx_error),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .mem_req(mem_req), .mem_wr(mem_wr), .mem_ack(mem_ack),
    .mem_err(mem_err));
  sirt_host_mem i_sirt_host_mem (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_wr(mem_wr),
    .delay(delay), .fail(fail), .mem_ack(mem_ack), .mem_err(mem_err),
    .last_addr(last_addr), .last_data(last_data), .writes(writes));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic print_verdict;
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse_reset;
    @(posedge pclk);
    bus_reset_seen <= 1'b1;
    @(posedge pclk);
    bus_reset_seen <= 1'b0;
  endtask

  // Waits for every write, since a new start must not overlap them
  task automatic recv(input int n, input logic e, input logic [31:0] d0);
    int i;
    logic [15:0] w0;
    w0 = writes;
    @(posedge pclk);
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    for (i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= d0 + i;
      do begin
        @(posedge pclk);
        if (rx_ready !== 1'b1) saw_full = 1'b1;
      end while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_error <= e;
    @(posedge pclk);
    rx_end <= 1'b0;
    rx_error <= 1'b0;
    while (writes !== w0 + 16'(n)) begin
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, bus_reset_seen} = 5'h00;
    {rx_start, rx_end, rx_error, rx_valid, fail, saw_full} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    rx_data = 32'h00000000;
    delay = 8'h02;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, BASE_OFF, 0);
    chk(rd, 32'h0);
    chk(err, 32'h0);
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h0);
    apb(1, BASE_OFF, 32'hffffffff);
    apb(0, BASE_OFF, 0);
    chk(rd, 32'hfffff800);
    apb(1, STAT_OFF, 32'hffffffff);
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h0);
    apb(0, 12'h06c, 0);
    chk(err, 32'h1);
    apb(1, BASE_OFF, 32'h12345abc);
    apb(0, BASE_OFF, 0);
    chk(rd, 32'h12345800);
    recv(5, 0, 32'h000000a0);
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h14);
    chk(last_addr, 32'h12345810);
    chk(last_data, 32'ha4);
    recv(2, 1, 32'h000000b0);
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h80000008);
    fail <= 1'b1;
    recv(1, 0, 32'h000000c0);
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h80000004);
    fail <= 1'b0;
    recv(3, 0, 32'h000000d0);
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h0000000c);
    // Slow memory stalls the writer until the buffer refuses data
    delay <= 8'd40;
    recv(20, 0, 32'h00000100);
    chk(saw_full, 32'h1);
    chk(last_addr, 32'h1234584c);
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h00000050);
    repeat (3) pulse_reset();
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h00030050);
    repeat (252) pulse_reset();
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h00ff0050);
    pulse_reset();
    apb(0, STAT_OFF, 0);
    chk(rd, 32'h00000050);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
